// [core/pbg_top.sv]
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pbg_top (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // AXI4-Lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Second port pins
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  output logic [7:0] pullup_en,
  output logic [7:0] analog_sel,
  // First port change pins and their direction
  input wire logic [1:0] first_port_pins_in,
  input wire logic [1:0] first_port_dir,
  input wire logic first_port_read,
  // Configuration and PWM sharing
  input wire logic timer_osc_pin_select,
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_own,
  // Interrupt
  output logic change_irq,
  output logic change_irq_high,
  output logic wake_req
);
  logic [7:0] second_port_direction;
  logic [7:0] second_port_output_latch;
  logic [7:0] interrupt_ctrl_reg1;
  logic [7:0] interrupt_ctrl_reg2;
  logic [7:0] analog_cfg;
  logic cfg_loaded;
  logic change_irq_flag;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic do_read;
  logic port_touch;
  logic [3:0] cur_val;
  logic [3:0] cur_in;
  logic [3:0] ref_val;
  logic [3:0] diff;
  logic mismatch;
  logic [31:0] next_rdata;

  // Byte address match on a word-aligned register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a[31:2] == ofs[31:2]);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = hit(a, pbg_pkg::OFS_PINS) || hit(a, pbg_pkg::OFS_LATCH) ||
      hit(a, pbg_pkg::OFS_DIR) || hit(a, pbg_pkg::OFS_ICR1) ||
      hit(a, pbg_pkg::OFS_ICR2) || hit(a, pbg_pkg::OFS_ANSEL) ||
      hit(a, pbg_pkg::OFS_FIRST);
  endfunction

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  // Write address and data taken separately, in either order
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_have <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      w_have <= 1'b0;
      w_data <= '0;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_have <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have <= 1'b1;
      w_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have && !s_axi_bvalid;
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pbg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? pbg_pkg::RESP_OKAY : pbg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Direction register, all inputs after reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      second_port_direction <= pbg_pkg::RST_DIR;
    end else if (do_write && hit(aw_addr, pbg_pkg::OFS_DIR)) begin
      second_port_direction <= w_data[7:0];
    end
  end

  // Output latch written through either the latch or the port address
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      second_port_output_latch <= pbg_pkg::RST_LATCH;
    end else if (do_write && (hit(aw_addr, pbg_pkg::OFS_LATCH) ||
                              hit(aw_addr, pbg_pkg::OFS_PINS))) begin
      second_port_output_latch <= w_data[7:0];
    end
  end

  // First control register; its bit 0 is shown from the change flag instead
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_ctrl_reg1 <= pbg_pkg::RST_ICR1;
    end else if (do_write && hit(aw_addr, pbg_pkg::OFS_ICR1)) begin
      interrupt_ctrl_reg1 <= w_data[7:0];
    end
  end

  // Second control register; pull-ups start disabled, priority high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_ctrl_reg2 <= pbg_pkg::RST_ICR2;
    end else if (do_write && hit(aw_addr, pbg_pkg::OFS_ICR2)) begin
      interrupt_ctrl_reg2 <= w_data[7:0];
    end
  end

  // The strap is caught once, on the first clock after reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_loaded <= 1'b0;
    end else begin
      cfg_loaded <= 1'b1;
    end
  end

  // Analog select: strap default first, then software may change pins 2 and 3
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      analog_cfg <= 8'h00;
    end else if (!cfg_loaded) begin
      analog_cfg <= timer_osc_pin_select ? 8'h00 : pbg_pkg::ANALOG_MASK;
    end else if (do_write && hit(aw_addr, pbg_pkg::OFS_ANSEL)) begin
      analog_cfg <= w_data[7:0] & pbg_pkg::ANALOG_MASK;
    end
  end

  // A bus access to the port, read or write, refreshes the reference
  assign port_touch = (do_read && hit(s_axi_araddr, pbg_pkg::OFS_PINS)) ||
    (do_write && hit(aw_addr, pbg_pkg::OFS_PINS)) || first_port_read;

  assign cur_val = {second_port_pins_in[3:2], first_port_pins_in};
  assign cur_in = {second_port_direction[3:2], first_port_dir};

  pbg_ref #(
    .W(4)
  ) u_ref (
    .clock(clock),
    .arst_n(arst_n),
    .load(port_touch),
    .value(cur_val),
    .held(ref_val)
  );

  // Per-pin mismatch, kept apart so a single pin can be traced
  assign diff = (cur_val ^ ref_val) & cur_in;
  // Combinational, so a pin going back clears its mismatch by itself
  assign mismatch = |diff;

  // Flag set wins over a software clear while the mismatch lasts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      change_irq_flag <= 1'b0;
    end else if (mismatch) begin
      change_irq_flag <= 1'b1;
    end else if (do_write && hit(aw_addr, pbg_pkg::OFS_ICR1)) begin
      change_irq_flag <= w_data[pbg_pkg::BIT_FLAG];
    end
  end

  // Read data registered; port reads give pin levels
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(s_axi_araddr, pbg_pkg::OFS_PINS)) begin
      next_rdata[7:0] = second_port_pins_in;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_LATCH)) begin
      next_rdata[7:0] = second_port_output_latch;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_DIR)) begin
      next_rdata[7:0] = second_port_direction;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_ICR1)) begin
      next_rdata[7:0] = interrupt_ctrl_reg1;
      next_rdata[pbg_pkg::BIT_FLAG] = change_irq_flag;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_ICR2)) begin
      next_rdata[7:0] = interrupt_ctrl_reg2;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_ANSEL)) begin
      next_rdata[7:0] = analog_cfg;
    end else if (hit(s_axi_araddr, pbg_pkg::OFS_FIRST)) begin
      next_rdata[1:0] = first_port_pins_in;
    end
  end

  // Read handshake; a new address is taken only once the answer is gone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read data and response, held unchanged while the answer waits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= pbg_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= mapped(s_axi_araddr) ? pbg_pkg::RESP_OKAY : pbg_pkg::RESP_SLVERR;
    end
  end

  // Pins driven this cycle: outputs, and PWM on the pins it may own
  function automatic logic [7:0] driven(input logic [7:0] dir, input logic [7:0] own);
    driven = ~dir | (own & ~pbg_pkg::CHANGE_MASK);
  endfunction

  // Drive value; PWM takes over pins 0,1,4-7 when it owns them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      second_port_pins_out <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pwm_own[i] && !pbg_pkg::CHANGE_MASK[i]) begin
          second_port_pins_out[i] <= pwm_out[i];
        end else begin
          second_port_pins_out[i] <= second_port_output_latch[i];
        end
      end
    end
  end

  // Output enable; a direction bit of one leaves the pin floating unless PWM owns it (pins 0,1,4-7)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      second_port_pins_oe <= 8'h00;
    end else begin
      second_port_pins_oe <= driven(second_port_direction, pwm_own);
    end
  end

  // Pull-ups under the active-low control; a PWM pin counts as driven too,
  // so the weak pull-up never fights the latch or PWM driver on the pad
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pullup_en <= 8'h00;
    end else begin
      pullup_en <= ~driven(second_port_direction, pwm_own) &
        {8{!interrupt_ctrl_reg2[pbg_pkg::BIT_PUDIS]}};
    end
  end

  // Analog selection only while the pin is an input
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      analog_sel <= 8'h00;
    end else begin
      analog_sel <= analog_cfg & second_port_direction;
    end
  end

  // Interrupt to the core: flag gated by its enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      change_irq <= 1'b0;
    end else begin
      change_irq <= change_irq_flag && interrupt_ctrl_reg1[pbg_pkg::BIT_IEN];
    end
  end

  // High-priority copy, raised only while the priority bit is set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      change_irq_high <= 1'b0;
    end else begin
      change_irq_high <= change_irq_flag && interrupt_ctrl_reg1[pbg_pkg::BIT_IEN] &&
        interrupt_ctrl_reg2[pbg_pkg::BIT_PRIO];
    end
  end

  // Wake request ignores any global enable, so Sleep and Idle can always end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= change_irq_flag && interrupt_ctrl_reg1[pbg_pkg::BIT_IEN];
    end
  end
endmodule
`default_nettype wire

// [core/pbg_pkg.sv]
// Functional notes
// - Eight-pin port with per-pin direction register
// - Direction bit one tristates the pin
// - Direction bit zero drives latch value
// - Output latch readable, returns latch contents
// - Global active-low pull-up bit enables all
// - Output pins never get pull-up
// - Pull-ups disabled after power-on reset
// - Reset makes inputs; pins 2,3 analog option
// - Pins 0,1,4-7 shared with PWM outputs
// - Pins 2,3 shared with interrupt, comparator, oscillator
// - Only input-configured change pins are compared
// - Compare against values captured at port read
// - ORed mismatches set change flag bit 0
// - Enabled change interrupt raises wake request
// - Persisting mismatch keeps setting the flag
// - Port read refreshes reference values
// - Pin returning to old level ends mismatch
// - Enable bit 3, priority bit 0 of controls
package pbg_pkg;
  localparam logic [31:0] OFS_PINS = 32'h0000_0000;
  localparam logic [31:0] OFS_LATCH = 32'h0000_0004;
  localparam logic [31:0] OFS_DIR = 32'h0000_0008;
  localparam logic [31:0] OFS_ICR1 = 32'h0000_000C;
  localparam logic [31:0] OFS_ICR2 = 32'h0000_0010;
  localparam logic [31:0] OFS_ANSEL = 32'h0000_0014;
  localparam logic [31:0] OFS_FIRST = 32'h0000_0018;
  localparam int BIT_FLAG = 0;
  localparam int BIT_IEN = 3;
  localparam int BIT_PRIO = 0;
  localparam int BIT_PUDIS = 7;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_ICR1 = 8'h00;
  localparam logic [7:0] RST_ICR2 = 8'h81;
  localparam logic [7:0] ANALOG_MASK = 8'h0C;
  localparam logic [7:0] CHANGE_MASK = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/pbg_ref.sv]
`timescale 1ns/1ps
`default_nettype none
// Reference store for the change comparison, refreshed on a port read
module pbg_ref #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Capture
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic [W-1:0] held
);
  // Last captured levels; they only move while load is high (a port read or write)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      held <= '0;
    end else if (load) begin
      held <= value;
    end
  end
endmodule
`default_nettype wire

// [dv/pbg_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pbg_top_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Pins and interrupt
  input wire logic [7:0] second_port_pins_out,
  input wire logic [7:0] second_port_pins_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] analog_sel,
  input wire logic [7:0] pwm_out,
  input wire logic [7:0] pwm_own,
  input wire logic change_irq,
  input wire logic change_irq_high,
  input wire logic wake_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Pad relations
  property p_pu_off; (pullup_en & second_port_pins_oe) == 8'h00; endproperty
  property p_ana; (analog_sel & 8'hF3) == 8'h00; endproperty
  property p_pwm;
    pwm_own[0] |=> second_port_pins_oe[0] && second_port_pins_out[0] == $past(pwm_out[0]);
  endproperty
  // Interrupt outputs
  property p_hi; change_irq_high |-> change_irq; endproperty
  property p_wake; wake_req == change_irq; endproperty
  // Bus answers hold until taken, reads answer next cycle
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up on driven pin");
  a_ana: assert property (p_ana) else $error("analog select off pins 2 and 3");
  a_pwm: assert property (p_pwm) else $error("pwm pin not driven");
  a_hi: assert property (p_hi) else $error("high priority without irq");
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  c_irq: cover property ($rose(change_irq));
  c_pu: cover property (pullup_en != 8'h00);
  c_pwm: cover property (pwm_own[0] && second_port_pins_oe[0]);
endmodule
bind pbg_top pbg_top_checker u_chk (.clock(clock), .arst_n(arst_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .second_port_pins_out(second_port_pins_out),
  .second_port_pins_oe(second_port_pins_oe), .pullup_en(pullup_en), .analog_sel(analog_sel),
  .pwm_out(pwm_out), .pwm_own(pwm_own), .change_irq(change_irq),
  .change_irq_high(change_irq_high), .wake_req(wake_req));
`default_nettype wire

// [dv/pbg_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module pbg_pins (
  // Clock
  input wire logic clock,
  // Device pad controls
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  input wire logic [7:0] pullup_en,
  // Outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pin level
  output logic [7:0] level
);
  logic [7:0] drift = 8'h55;
  // Floating pins wander so a stale value never reads as valid
  always @(posedge clock) drift <= ~drift;
  // Device driver wins, then outside driver, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = pins_oe[i] ? pins_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] | drift[i];
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic clock, arst_n, fp_rd, tosel, irq, irq_hi, wake;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, fp_in, fp_dir;
  logic [7:0] p_in, p_out, p_oe, pu, an, pwm_out, pwm_own, ext_val, ext_en;
  int err_count, checks_done, cyc;
  pbg_top uut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .second_port_pins_in(p_in), .second_port_pins_out(p_out),
    .second_port_pins_oe(p_oe), .pullup_en(pu), .analog_sel(an), .first_port_pins_in(fp_in),
    .first_port_dir(fp_dir), .first_port_read(fp_rd), .timer_osc_pin_select(tosel),
    .pwm_out(pwm_out), .pwm_own(pwm_own), .change_irq(irq), .change_irq_high(irq_hi),
    .wake_req(wake));
  pbg_pins u_pins (.clock(clock), .pins_out(p_out), .pins_oe(p_oe), .pullup_en(pu),
    .ext_val(ext_val), .ext_en(ext_en), .level(p_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge clock);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clock);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, {24'h0, e})
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {arst_n, fp_rd, tosel, fp_in} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {pwm_out, pwm_own, ext_val} = '0;
    ext_en = 8'hFF;
    fp_dir = 2'h3;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    pause(3);
    `CHK(an, 8'h0C)
    `CHK(pu, 8'h00)
    `CHK(p_oe, 8'h00)
    rc(pbg_pkg::OFS_DIR, 8'hFF);
    rc(pbg_pkg::OFS_LATCH, 8'h00);
    rc(pbg_pkg::OFS_ICR1, 8'h00);
    rc(pbg_pkg::OFS_ICR2, 8'h81);
    rd(32'h0000_0040, d);
    `CHK(s_axi_rdata, 32'h0000_0000)
    wr(32'h0000_0040, 8'h55);
    `CHK(rsp, pbg_pkg::RESP_SLVERR)
    // Latch versus pins, with the low nibble as inputs
    wr(pbg_pkg::OFS_ANSEL, 8'h00);
    wr(pbg_pkg::OFS_LATCH, 8'hA5);
    `CHK(rsp, pbg_pkg::RESP_OKAY)
    wr(pbg_pkg::OFS_DIR, 8'h0F);
    ext_val <= 8'h06;
    pause(3);
    `CHK(p_oe, 8'hF0)
    `CHK(p_out[7:4], 4'hA)
    rc(pbg_pkg::OFS_PINS, 8'hA6);
    rc(pbg_pkg::OFS_LATCH, 8'hA5);
    wr(pbg_pkg::OFS_ICR2, 8'h01);
    ext_en <= 8'hF0;
    pause(3);
    `CHK(pu, 8'h0F)
    rc(pbg_pkg::OFS_PINS, 8'hAF);
    wr(pbg_pkg::OFS_PINS, 8'h3C);
    rc(pbg_pkg::OFS_LATCH, 8'h3C);
    // A write without byte lane 0 lands as zero
    s_axi_wstrb <= 4'hE;
    wr(pbg_pkg::OFS_LATCH, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rc(pbg_pkg::OFS_LATCH, 8'h00);
    wr(pbg_pkg::OFS_LATCH, 8'h3C);
    pwm_own <= 8'h01;
    pwm_out <= 8'h01;
    pause(3);
    `CHK(p_oe[0], 1'b1)
    `CHK(p_out[0], 1'b1)
    `CHK(pu, 8'h0E)
    pwm_own <= 8'h00;
    // Change detection on all-input port
    wr(pbg_pkg::OFS_DIR, 8'hFF);
    wr(pbg_pkg::OFS_ICR2, 8'h81);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    pause(3);
    rd(pbg_pkg::OFS_PINS, d);
    wr(pbg_pkg::OFS_ICR1, 8'h08);
    pause(2);
    `CHK(irq, 1'b0)
    ext_val <= 8'h04;
    pause(4);
    `CHK(irq, 1'b1)
    `CHK(wake, 1'b1)
    `CHK(irq_hi, 1'b1)
    wr(pbg_pkg::OFS_ICR1, 8'h08);
    pause(2);
    `CHK(irq, 1'b1)
    ext_val <= 8'h00;
    pause(3);
    wr(pbg_pkg::OFS_ICR1, 8'h08);
    pause(2);
    `CHK(irq, 1'b0)
    ext_val <= 8'h08;
    pause(4);
    rc(pbg_pkg::OFS_ICR1, 8'h09);
    rd(pbg_pkg::OFS_PINS, d);
    pause(1);
    wr(pbg_pkg::OFS_ICR1, 8'h08);
    pause(2);
    `CHK(irq, 1'b0)
    // Pin 3 as output stays out of the comparison
    wr(pbg_pkg::OFS_DIR, 8'hF7);
    wr(pbg_pkg::OFS_LATCH, 8'h34);
    pause(4);
    `CHK(irq, 1'b0)
    fp_in <= 2'b01;
    pause(4);
    `CHK(irq, 1'b1)
    fp_rd <= 1'b1;
    pause(1);
    fp_rd <= 1'b0;
    wr(pbg_pkg::OFS_ICR1, 8'h08);
    pause(2);
    `CHK(irq, 1'b0)
    wr(pbg_pkg::OFS_ICR2, 8'h80);
    fp_in <= 2'b00;
    pause(4);
    `CHK(irq, 1'b1)
    `CHK(irq_hi, 1'b0)
    // Second reset with pull-ups on and the strap set the other way
    wr(pbg_pkg::OFS_ICR2, 8'h00);
    pause(2);
    `CHK(pu, 8'hF7)
    tosel <= 1'b1;
    arst_n <= 1'b0;
    pause(2);
    `CHK(pu, 8'h00)
    arst_n <= 1'b1;
    pause(3);
    `CHK(pu, 8'h00)
    `CHK(an, 8'h00)
    `CHK(p_oe, 8'h00)
    `CHK(irq, 1'b0)
    rc(pbg_pkg::OFS_DIR, 8'hFF);
    rc(pbg_pkg::OFS_ICR2, 8'h81);
    end_sim();
  end
endmodule
`default_nettype wire
